// >>> pkg/umsr_pkg.sv
// Package for the modem status, scratch swap and divisor register block
package umsr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (Wishbone byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODEM_STATUS = 8'h00;
    localparam logic [7:0] OFS_SCRATCH = 8'h04;
    localparam logic [7:0] OFS_DIV_LOW = 8'h08;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h0c;
    localparam logic [7:0] OFS_DIV_FRAC = 8'h10;
    localparam logic [7:0] OFS_IDENTITY = 8'h14;
    localparam logic [7:0] OFS_REVISION = 8'h18;
    localparam logic [7:0] OFS_TRIGGER = 8'h1c;
    localparam logic [7:0] OFS_FIFO_COUNT = 8'h20;
    localparam logic [7:0] OFS_LINE_CTRL = 8'h24;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h28;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h2c;
    localparam logic [7:0] OFS_FEATURE_CTRL = 8'h30;
    localparam logic [7:0] OFS_ENH_FEATURE = 8'h34;
    localparam logic [7:0] OFS_ENHANCED_MODE_SELECT_VIEW = 8'h38;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IE_MODEM_BIT = 3;
    localparam int MC_DTR_BIT = 0;
    localparam int MC_RTS_BIT = 1;
    localparam int MC_OUT1_BIT = 2;
    localparam int MC_OUT2_BIT = 3;
    localparam int MC_LOOP_BIT = 4;
    localparam int FC_SWAP_BIT = 6;
    localparam int FC_TRGSEL_BIT = 7;
    localparam int EF_ENH_BIT = 4;
    localparam int EF_AUTOCTS_BIT = 7;
    localparam int EM_LSRIMM_BIT = 6;
    localparam int EM_SAMP16_BIT = 7;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] SCRATCH_RST = 8'hff;
    localparam logic [7:0] ENHANCED_MODE_SELECT_RST = 8'h80;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] LCR_FEATURE_KEY = 8'hbf;
    // Arbitrary identity values
    localparam logic [7:0] IDENTITY_CODE = 8'h5c;
    localparam logic [7:0] REVISION_CODE = 8'h03;

    // Level count modes
    typedef enum logic [1:0] {
        UMSR_CNT_RX = 2'b00,
        UMSR_CNT_TX = 2'b01,
        UMSR_CNT_ALT = 2'b11
    } umsr_cnt_e;

    // Modem input group, active low as on pins
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } umsr_modem_s;

    // Datapath controls
    typedef struct packed {
        logic [15:0] div_int;
        logic [3:0] div_frac;
        logic [5:0] rts_hyst;
        logic lsr_immediate;
        logic sample_16x;
        logic tx_halt;
        logic msr_irq;
    } umsr_ctrl_s;

endpackage

// >>> hw/umsr_regs.sv
// Modem status, scratch swap, fifo level and divisor register block
//
// Summary of operation
// - Delta CTS/DSR/CD on change, interrupt if enabled
// - Delta RI only on ring end edge
// - Auto CTS high halts transmit after character
// - Bit 4 inverse CTS, loopback RTS
// - Bit 5 loopback follows DTR bit
// - Bit 6 inverse RI, loopback control bit 2
// - Bit 7 inverse CD, loopback control bit 3
// - Scratch register, reset value all ones
// - Swap steers scratch writes to mode register
// - Mode bits select RX, TX, alternating count
// - Alternating reads start RX then TX
// - Four bit code selects RTS hysteresis
// - Line status interrupt delayed or immediate
// - Mode bit 7 selects 8x or 16x
// - Swap reads return fifo level value
// - Divisor is integer plus fraction over sixteen
// - Fraction writable only with enhanced enable
// - Identity code readable, divisor zero first
// - Revision code readable, divisor zero first
// - Trigger register programs RX or TX level
// - Count register only with line control BF
`timescale 1ns/1ps
module umsr_regs
    import umsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Modem inputs, active low
    input wire umsr_modem_s modem_i,
    // Fifo levels from the datapath
    input wire logic [7:0] rx_level_i,
    input wire logic [7:0] tx_level_i,
    // Transmitter character boundary
    input wire logic tx_char_done_i,
    // Datapath controls
    output umsr_ctrl_s ctrl_o,
    output logic [7:0] rx_trigger_o,
    output logic [7:0] tx_trigger_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] hyst_of(input logic [3:0] code);
        case (code)
            4'h0: hyst_of = 6'd0;
            4'h1: hyst_of = 6'd4;
            4'h2: hyst_of = 6'd6;
            4'h3: hyst_of = 6'd8;
            4'h4: hyst_of = 6'd8;
            4'h5: hyst_of = 6'd16;
            4'h6: hyst_of = 6'd24;
            4'h7: hyst_of = 6'd32;
            4'h8: hyst_of = 6'd40;
            4'h9: hyst_of = 6'd44;
            4'ha: hyst_of = 6'd48;
            4'hb: hyst_of = 6'd52;
            4'hc: hyst_of = 6'd12;
            4'hd: hyst_of = 6'd20;
            4'he: hyst_of = 6'd28;
            default: hyst_of = 6'd36;
        endcase
    endfunction

    function automatic umsr_cnt_e cnt_mode(input logic [1:0] bits);
        cnt_mode = !bits[0] ? UMSR_CNT_RX : (!bits[1] ? UMSR_CNT_TX : UMSR_CNT_ALT);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] line_control_q;
    logic [7:0] modem_control_q;
    logic [7:0] interrupt_enable_q;
    logic [7:0] feature_control_q;
    logic [7:0] enhanced_feature_q;
    logic [7:0] scratch_pad_q;
    logic [7:0] enhanced_mode_select_q;
    logic [7:0] divisor_low_q;
    logic [7:0] divisor_high_q;
    logic [3:0] divisor_fraction_q;
    logic [7:0] rx_trig_q;
    logic [7:0] tx_trig_q;
    logic [3:0] delta_q;
    umsr_modem_s modem_prev_q;
    logic alt_tx_q;
    logic tx_halt_q;

    logic access;
    logic wr;
    logic rd;
    logic swap;
    logic [7:0] wbyte;
    logic [7:0] status_view;
    logic [7:0] level_view;
    logic [3:0] delta_set;
    logic [31:0] rdata_d;
    umsr_cnt_e mode;
    logic [3:0] hyst_code;

    // Single cycle answer; ack drops the cycle after it is given
    assign access = cyc_i && stb_i && !ack_o;
    assign wr = access && we_i && sel_i[0];
    assign rd = access && !we_i;
    assign wbyte = dat_i[7:0];
    assign swap = feature_control_q[FC_SWAP_BIT];
    assign mode = cnt_mode(enhanced_mode_select_q[1:0]);
    assign hyst_code = {enhanced_mode_select_q[5:4], feature_control_q[1:0]};

    // ------------------------------------------------------------
    // Modem status view
    // ------------------------------------------------------------
    always_comb
    begin
        if (modem_control_q[MC_LOOP_BIT])
        begin
            status_view[4] = modem_control_q[MC_RTS_BIT];
            status_view[5] = modem_control_q[MC_DTR_BIT];
            status_view[6] = modem_control_q[MC_OUT1_BIT];
            status_view[7] = modem_control_q[MC_OUT2_BIT];
        end
        else
        begin
            status_view[4] = !modem_i.cts_n;
            status_view[5] = !modem_i.dsr_n;
            status_view[6] = !modem_i.ri_n;
            status_view[7] = !modem_i.cd_n;
        end
        status_view[3:0] = delta_q;
    end

    // change detect on CTS, DSR, CD
    assign delta_set[0] = modem_i.cts_n != modem_prev_q.cts_n;
    assign delta_set[1] = modem_i.dsr_n != modem_prev_q.dsr_n;
    // ring end, low to high only
    assign delta_set[2] = modem_i.ri_n && !modem_prev_q.ri_n;
    assign delta_set[3] = modem_i.cd_n != modem_prev_q.cd_n;

    // Set wins over the read clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            modem_prev_q <= '1;
            delta_q <= 4'h0;
        end
        else
        begin
            modem_prev_q <= modem_i;
            delta_q <= delta_set | ((rd && adr_i == OFS_MODEM_STATUS) ? 4'h0 : delta_q);
        end
    end

    // ------------------------------------------------------------
    // Fifo level view and alternation
    // ------------------------------------------------------------
    always_comb
    begin
        case (mode)
            UMSR_CNT_RX: level_view = rx_level_i;
            UMSR_CNT_TX: level_view = tx_level_i;
            UMSR_CNT_ALT: level_view = alt_tx_q ? tx_level_i : rx_level_i;
            default: level_view = rx_level_i;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alt_tx_q <= 1'b0;
        end
        else if (wr && swap && adr_i == OFS_SCRATCH)
        begin
            alt_tx_q <= 1'b0;
        end
        else if (rd && swap && adr_i == OFS_SCRATCH && mode == UMSR_CNT_ALT)
        begin
            alt_tx_q <= !alt_tx_q;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_control_q <= ZERO8;
            modem_control_q <= ZERO8;
            interrupt_enable_q <= ZERO8;
            feature_control_q <= ZERO8;
            enhanced_feature_q <= ZERO8;
        end
        else if (wr)
        begin
            case (adr_i)
                OFS_LINE_CTRL: line_control_q <= wbyte;
                OFS_MODEM_CTRL: modem_control_q <= wbyte;
                OFS_INT_ENABLE: interrupt_enable_q <= wbyte;
                OFS_FEATURE_CTRL: feature_control_q <= wbyte;
                OFS_ENH_FEATURE: enhanced_feature_q <= wbyte;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scratch_pad_q <= SCRATCH_RST;
            enhanced_mode_select_q <= ENHANCED_MODE_SELECT_RST;
        end
        else if (wr && adr_i == OFS_SCRATCH)
        begin
            if (swap)
            begin
                enhanced_mode_select_q <= wbyte;
            end
            else
            begin
                scratch_pad_q <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            divisor_low_q <= ZERO8;
            divisor_high_q <= ZERO8;
            divisor_fraction_q <= 4'h0;
        end
        else if (wr)
        begin
            if (adr_i == OFS_DIV_LOW)
            begin
                divisor_low_q <= wbyte;
            end
            if (adr_i == OFS_DIV_HIGH)
            begin
                divisor_high_q <= wbyte;
            end
            if (adr_i == OFS_DIV_FRAC && enhanced_feature_q[EF_ENH_BIT])
            begin
                divisor_fraction_q <= wbyte[3:0];
            end
        end
    end

    // trigger target picked by feature bit 7
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_trig_q <= ZERO8;
            tx_trig_q <= ZERO8;
        end
        else if (wr && adr_i == OFS_TRIGGER)
        begin
            if (feature_control_q[FC_TRGSEL_BIT])
            begin
                tx_trig_q <= wbyte;
            end
            else
            begin
                rx_trig_q <= wbyte;
            end
        end
    end

    // halt only at a character boundary
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_halt_q <= 1'b0;
        end
        else if (!enhanced_feature_q[EF_AUTOCTS_BIT] || !modem_i.cts_n)
        begin
            tx_halt_q <= 1'b0;
        end
        else if (tx_char_done_i)
        begin
            tx_halt_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read mux and bus answer
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_d = 32'h0;
        case (adr_i)
            OFS_MODEM_STATUS: rdata_d[7:0] = status_view;
            OFS_SCRATCH: rdata_d[7:0] = swap ? level_view : scratch_pad_q;
            OFS_DIV_LOW: rdata_d[7:0] = divisor_low_q;
            OFS_DIV_HIGH: rdata_d[7:0] = divisor_high_q;
            OFS_DIV_FRAC: rdata_d[3:0] = divisor_fraction_q;
            OFS_IDENTITY: rdata_d[7:0] =
                ({divisor_high_q, divisor_low_q} == 16'h0) ? IDENTITY_CODE : ZERO8;
            OFS_REVISION: rdata_d[7:0] =
                ({divisor_high_q, divisor_low_q} == 16'h0) ? REVISION_CODE : ZERO8;
            OFS_FIFO_COUNT: rdata_d[7:0] = (line_control_q != LCR_FEATURE_KEY) ? ZERO8 :
                (feature_control_q[FC_TRGSEL_BIT] ? tx_level_i : rx_level_i);
            OFS_LINE_CTRL: rdata_d[7:0] = line_control_q;
            OFS_MODEM_CTRL: rdata_d[7:0] = modem_control_q;
            OFS_INT_ENABLE: rdata_d[7:0] = interrupt_enable_q;
            OFS_FEATURE_CTRL: rdata_d[7:0] = feature_control_q;
            OFS_ENH_FEATURE: rdata_d[7:0] = enhanced_feature_q;
            OFS_ENHANCED_MODE_SELECT_VIEW: rdata_d[7:0] = enhanced_mode_select_q;
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= access;
            dat_o <= rd ? rdata_d : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Control outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_o <= '0;
            ctrl_o.sample_16x <= 1'b1;
            rx_trigger_o <= ZERO8;
            tx_trigger_o <= ZERO8;
        end
        else
        begin
            ctrl_o.div_int <= {divisor_high_q, divisor_low_q};
            ctrl_o.div_frac <= divisor_fraction_q;
            ctrl_o.rts_hyst <= hyst_of(hyst_code);
            ctrl_o.lsr_immediate <= enhanced_mode_select_q[EM_LSRIMM_BIT];
            ctrl_o.sample_16x <= enhanced_mode_select_q[EM_SAMP16_BIT];
            ctrl_o.tx_halt <= tx_halt_q;
            ctrl_o.msr_irq <= interrupt_enable_q[IE_MODEM_BIT] && (delta_q != 4'h0);
            rx_trigger_o <= rx_trig_q;
            tx_trigger_o <= tx_trig_q;
        end
    end

endmodule

// >>> test/umsr_regs_asserts.sv
// Checker for the modem status and divisor register block
`timescale 1ns/1ps
module umsr_regs_asserts
    import umsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Datapath side
    input wire umsr_modem_s modem_i,
    input wire logic [7:0] rx_level_i,
    input wire logic [7:0] tx_level_i,
    input wire logic tx_char_done_i,
    input wire umsr_ctrl_s ctrl_o,
    input wire logic [7:0] rx_trigger_o,
    input wire logic [7:0] tx_trigger_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Writes land up to three edges before the output moves
    wire req = cyc_i && stb_i && !ack_o;
    wire wr = cyc_i && stb_i && we_i;
    wire w_div = wr && (adr_i == OFS_DIV_LOW || adr_i == OFS_DIV_HIGH || adr_i == OFS_DIV_FRAC);
    wire w_trg = wr && adr_i == OFS_TRIGGER;
    wire w_hys = wr && (adr_i == OFS_SCRATCH || adr_i == OFS_FEATURE_CTRL);
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held more than one cycle");
    a_ack_answer: assert property (req |=> ack_o)
        else $error("request not answered next cycle");
    a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_vals: assert property ($fell(rst_i) |-> ctrl_o.sample_16x && ctrl_o.div_int == 16'h0)
        else $error("control values wrong after reset");
    a_halt_boundary: assert property ($rose(ctrl_o.tx_halt) |-> $past(tx_char_done_i && modem_i.cts_n, 2))
        else $error("halt without character end");
    a_halt_release: assert property (!modem_i.cts_n |-> ##2 !ctrl_o.tx_halt)
        else $error("halt kept while clear to send");
    a_div_by_write: assert property (($changed(ctrl_o.div_int) || $changed(ctrl_o.div_frac))
        |-> $past(w_div) || $past(w_div, 2) || $past(w_div, 3))
        else $error("divisor moved without write");
    a_trig_by_write: assert property (($changed(rx_trigger_o) || $changed(tx_trigger_o))
        |-> $past(w_trg) || $past(w_trg, 2) || $past(w_trg, 3))
        else $error("trigger moved without write");
    a_hyst_by_write: assert property ($changed(ctrl_o.rts_hyst)
        |-> $past(w_hys) || $past(w_hys, 2) || $past(w_hys, 3))
        else $error("hysteresis moved without write");
    c_read: cover property (req && !we_i);
    c_halt: cover property ($rose(ctrl_o.tx_halt));
    c_irq: cover property ($rose(ctrl_o.msr_irq));
endmodule

bind umsr_regs umsr_regs_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .modem_i, .rx_level_i, .tx_level_i, .tx_char_done_i, .ctrl_o,
    .rx_trigger_o, .tx_trigger_o);

// >>> test/umsr_host_model.sv
// Host model driving the register bus
`timescale 1ns/1ps
module umsr_host_model
    import umsr_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Bus master
    output logic cyc_o = 1'b0,
    output logic stb_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [7:0] adr_o = 8'h00,
    output logic [3:0] sel_o = 4'h1,
    output logic [31:0] dat_o = 32'h0,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    // Ack and read data are sampled at the rising edge, released at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= {24'h0, d};
        do
            @(posedge clk_i);
        while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines show junk, not the old value
        adr_o <= ~a;
        dat_o <= ~{24'h0, d};
    endtask
    task automatic set_triggers(input logic [7:0] tx, input logic [7:0] rx);
        logic [31:0] q;
        xfer(1'b1, OFS_FEATURE_CTRL, 8'h80, q);
        xfer(1'b1, OFS_TRIGGER, tx, q);
        xfer(1'b1, OFS_FEATURE_CTRL, 8'h00, q);
        xfer(1'b1, OFS_TRIGGER, rx, q);
    endtask
    task automatic read_ids(output logic [31:0] id, output logic [31:0] rev);
        logic [31:0] q;
        xfer(1'b1, OFS_DIV_LOW, 8'h00, q);
        xfer(1'b1, OFS_DIV_HIGH, 8'h00, q);
        xfer(1'b0, OFS_IDENTITY, 8'h00, id);
        xfer(1'b0, OFS_REVISION, 8'h00, rev);
    endtask
endmodule

// >>> test/umsr_regs_tb.sv
// Self-checking bench for the modem status and divisor register block
`timescale 1ns/1ps
module umsr_regs_tb
    import umsr_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [7:0] adr, rxt, txt;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, q2;
    umsr_modem_s modem = 4'hf;
    logic [7:0] rx_lvl = 8'h11;
    logic [7:0] tx_lvl = 8'h22;
    logic tx_done = 1'b0;
    umsr_ctrl_s ctrl;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    logic [5:0] hyst [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
        6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
    umsr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .modem_i(modem),
        .rx_level_i(rx_lvl), .tx_level_i(tx_lvl), .tx_char_done_i(tx_done), .ctrl_o(ctrl),
        .rx_trigger_o(rxt), .tx_trigger_o(txt));
    umsr_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    // Hang guard, far above the expected run
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 8'h00, q);
        chk(nm, q, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic setm(input logic [3:0] v);
        @(posedge clk_i);
        modem <= v;
        tick(3);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        tick(20);
        rst_i <= 1'b0;
        rd("scratch", OFS_SCRATCH, 32'hff);
        rd("mode", OFS_ENHANCED_MODE_SELECT_VIEW, 32'h80);
        rd("msr", OFS_MODEM_STATUS, 32'h00);
        chk("lsr_imm", ctrl.lsr_immediate, 1'b0);
        chk("16x_rst", ctrl.sample_16x, 1'b1);
        $display("test reset done");
        wr(OFS_INT_ENABLE, 8'h08);
        setm(4'he);
        chk("irq", ctrl.msr_irq, 1'b1);
        rd("msr_cts", OFS_MODEM_STATUS, 32'h11);
        rd("msr_clr", OFS_MODEM_STATUS, 32'h10);
        tick(2);
        chk("irq_clr", ctrl.msr_irq, 1'b0);
        setm(4'ha);
        rd("ri_fall", OFS_MODEM_STATUS, 32'h50);
        setm(4'he);
        rd("ri_rise", OFS_MODEM_STATUS, 32'h14);
        setm(4'h0);
        rd("all_on", OFS_MODEM_STATUS, 32'hfa);
        wr(OFS_INT_ENABLE, 8'h00);
        setm(4'hf);
        chk("irq_mask", ctrl.msr_irq, 1'b0);
        rd("all_off", OFS_MODEM_STATUS, 32'h0f);
        for (int m = 0; m < 16; m++)
        begin
            wr(OFS_MODEM_CTRL, {4'h1, m[3:0]});
            host.xfer(1'b0, OFS_MODEM_STATUS, 8'h00, q);
            chk("loop", q[7:4], {m[3], m[2], m[0], m[1]});
        end
        wr(OFS_MODEM_CTRL, 8'h00);
        $display("test modem done");
        wr(OFS_SCRATCH, 8'h5a);
        rd("spr", OFS_SCRATCH, 32'h5a);
        wr(OFS_FEATURE_CTRL, 8'h40);
        wr(OFS_SCRATCH, 8'h82);
        rd("lvl_rx", OFS_SCRATCH, 32'h11);
        wr(OFS_SCRATCH, 8'h81);
        rd("lvl_tx", OFS_SCRATCH, 32'h22);
        wr(OFS_SCRATCH, 8'h83);
        rd("alt1", OFS_SCRATCH, 32'h11);
        rd("alt2", OFS_SCRATCH, 32'h22);
        rd("alt3", OFS_SCRATCH, 32'h11);
        rd("view", OFS_ENHANCED_MODE_SELECT_VIEW, 32'h83);
        wr(OFS_SCRATCH, 8'h43);
        tick(2);
        chk("8x", ctrl.sample_16x, 1'b0);
        chk("lsr_imm", ctrl.lsr_immediate, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            wr(OFS_FEATURE_CTRL, {6'h10, i[1:0]});
            wr(OFS_SCRATCH, {2'b10, i[3:2], 4'h0});
            tick(2);
            chk("hyst", ctrl.rts_hyst, hyst[i]);
        end
        wr(OFS_FEATURE_CTRL, 8'h00);
        rd("spr_kept", OFS_SCRATCH, 32'h5a);
        $display("test swap done");
        wr(OFS_DIV_LOW, 8'h34);
        wr(OFS_DIV_HIGH, 8'h12);
        rd("id_refused", OFS_IDENTITY, 32'h0);
        wr(OFS_DIV_FRAC, 8'h0b);
        tick(2);
        chk("div", ctrl.div_int, 16'h1234);
        chk("frac_lock", ctrl.div_frac, 4'h0);
        wr(OFS_ENH_FEATURE, 8'h10);
        wr(OFS_DIV_FRAC, 8'h0b);
        tick(2);
        chk("frac", ctrl.div_frac, 4'hb);
        host.read_ids(q, q2);
        chk("id", q, {24'h0, IDENTITY_CODE});
        chk("rev", q2, {24'h0, REVISION_CODE});
        host.set_triggers(8'h30, 8'h0c);
        tick(2);
        chk("txt", txt, 8'h30);
        chk("rxt", rxt, 8'h0c);
        rd("fc_lock", OFS_FIFO_COUNT, 32'h0);
        wr(OFS_LINE_CTRL, 8'hbf);
        rd("fc_rx", OFS_FIFO_COUNT, 32'h11);
        wr(OFS_FEATURE_CTRL, 8'h80);
        rd("fc_tx", OFS_FIFO_COUNT, 32'h22);
        wr(OFS_LINE_CTRL, 8'hbe);
        rd("fc_be", OFS_FIFO_COUNT, 32'h0);
        $display("test divisor done");
        wr(OFS_ENH_FEATURE, 8'h80);
        tick(3);
        chk("no_halt", ctrl.tx_halt, 1'b0);
        @(posedge clk_i);
        tx_done <= 1'b1;
        @(posedge clk_i);
        tx_done <= 1'b0;
        tick(2);
        chk("halt", ctrl.tx_halt, 1'b1);
        setm(4'he);
        chk("resume", ctrl.tx_halt, 1'b0);
        wr(8'h3c, 8'h77);
        rd("unmapped", 8'h3c, 32'h0);
        $display("test flow done");
        final_report();
    end
endmodule
